/* rtl/nic_core.sv */
// nic_core: nested interrupt controller of the 8-bit core. Latches the
// sources, arbitrates at instruction boundaries, drives the entry
// sequence and the priority level bits, and decides wake-up.
// Assumes synchronous inputs, an APB master, and a cpu that pushes its
// registers on stack_req and loads pc on vector_load.
//
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/10ps
module nic_core
  import nic_pkg::*;
(
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire nic_apb_req_s                 apb_req,
  output nic_apb_rsp_s                      apb_rsp,
  input  wire nic_cpu_in_s                  cpu_in,
  output nic_cpu_out_s                      cpu_out,
  input  wire logic                         tli_pin,
  input  wire logic [EXT_GROUPS*EXT_PINS-1:0] ext_pins,
  input  wire logic [NVEC-1:0]              periph_flag,
  input  wire logic [NVEC-1:0]              periph_irq_en,
  input  wire logic [NVEC-1:0]              periph_clear,
  input  wire logic                         supply_monitor_flag
);

  nic_state_s            s_reg;       // all state
  nic_state_s            s_next;      // next state
  logic                  tli_edge;    // selected edge on the pin
  logic [EXT_GROUPS-1:0] ext_or;      // ORed selected pins per group
  logic [EXT_GROUPS-1:0] ext_rise;    // new edge per group
  logic [NVEC-1:0]       preq;        // peripheral request level
  logic [NVEC-1:0]       set_v;       // latch set per vector
  logic [NVEC-1:0]       clr_v;       // latch clear per vector
  logic [NVEC-1:0]       entry_hit;   // vector entered this cycle
  logic [NVEC-1:0]       pend_arb;    // pending seen by the arbiter
  logic                  sup_toggle;  // supply monitor event
  logic                  halt_only;   // only halt-capable may go first
  logic                  win_valid;   // arbiter has a winner
  logic [3:0]            win_idx;     // arbiter winner
  logic                  entering;    // vector load cycle
  logic                  apb_wr;      // write completes this edge
  logic                  apb_setup;   // setup phase of a transfer
  logic                  mapped;      // address decodes
  logic [1:0]            entry_prio;  // stored level of the winner

  ////////////////////////////////////////////////////////////////////////
  // source conditioning
  assign tli_edge = s_reg.cfg[CFG_TLI_RISE_BIT]
                  ? (tli_pin & ~s_reg.tli_q)
                  : (~tli_pin & s_reg.tli_q);
  assign preq     = periph_flag & periph_irq_en;
  // the monitor flag interrupts on either transition when enabled
  assign sup_toggle = (supply_monitor_flag ^ s_reg.sup_q)
                    & s_reg.cfg[CFG_SUP_IE_BIT];
  assign entering = (s_reg.st == ST_VECTOR);
  assign ext_rise = ext_or & ~s_reg.ext_q;

  // one pass per external group and per vector
  for (genvar g = 0; g < EXT_GROUPS; g++) begin : g_ext
    // selected pins of a group share one line
    assign ext_or[g] = |(ext_pins[g*EXT_PINS +: EXT_PINS]
                       & s_reg.extsel[g*EXT_PINS +: EXT_PINS]);
  end

  for (genvar i = 0; i < NVEC; i++) begin : g_lat
    assign entry_hit[i] = entering & (s_reg.kind == KIND_VEC)
                        & (s_reg.idx == 4'(i));
    if (i == 0) begin : g_tli
      assign set_v[i] = tli_edge;
      assign clr_v[i] = entry_hit[i];
    end else if (i >= EXT_FIRST && i < EXT_FIRST + EXT_GROUPS) begin : g_e
      // edge latch drops on entry to its routine
      assign set_v[i] = ext_rise[i-EXT_FIRST];
      assign clr_v[i] = entry_hit[i];
    end else begin : g_p
      // only the clear sequence drops it, even if pending
      assign set_v[i] = preq[i] & ~s_reg.preq_q[i];
      assign clr_v[i] = periph_clear[i];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // arbitration input: during halt the monitor cannot compete
  assign halt_only = cpu_in.halted | s_reg.halt_first;
  always_comb begin
    pend_arb = s_reg.lat;
    // monitor event wakes from wait only
    if (!halt_only) begin
      pend_arb[SUP_IDX] = s_reg.lat[SUP_IDX] | s_reg.sup_lat;
    end
  end

  nic_arbiter u_arb (
    .pclk      (pclk),
    .presetn   (presetn),
    .pending   (pend_arb),
    // fields of vectors 0..13 only; the top nibble carries no vector
    .prio_flat (28'(s_reg.prio)),
    .cur_level (s_reg.level),
    .halt_only (halt_only),
    .win_valid (win_valid),
    .win_idx   (win_idx)
  );

  assign entry_prio = s_reg.prio[s_reg.idx[3:2]][{s_reg.idx[1:0], 1'b0} +: 2];

  ////////////////////////////////////////////////////////////////////////
  // apb decode
  assign apb_setup = apb_req.psel & ~apb_req.penable;
  assign apb_wr    = apb_req.psel & apb_req.penable & apb_req.pwrite;
  assign mapped    = (apb_req.paddr[1:0] == 2'h0)
                   && (apb_req.paddr <= OFF_STAT);

  // zero wait states: the read word was captured at setup
  assign apb_rsp.prdata  = s_reg.rdata;
  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.pslverr = apb_req.psel & apb_req.penable & ~mapped;

  ////////////////////////////////////////////////////////////////////////
  // cpu side
  assign cpu_out.stack_req   = (s_reg.st == ST_STACK);
  assign cpu_out.vector_load = entering;
  assign cpu_out.vector_addr = s_reg.vaddr;
  assign cpu_out.level       = s_reg.level;
  // masked or under-ranked requests never wake the core
  assign cpu_out.wake = (cpu_in.halted | cpu_in.waiting)
                      & (win_valid | s_reg.trap_pend);

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    s_next        = s_reg;
    s_next.tli_q  = tli_pin;
    s_next.ext_q  = ext_or;
    s_next.preq_q = preq;
    s_next.sup_q  = supply_monitor_flag;

    // set beats a clear landing in the same cycle
    s_next.lat     = set_v | (s_reg.lat & ~clr_v);
    s_next.sup_lat = sup_toggle
                   | (s_reg.sup_lat & ~entry_hit[SUP_IDX]);
    s_next.trap_pend = cpu_in.trap_exec
                     | (s_reg.trap_pend
                        & ~(entering & s_reg.kind == KIND_TRAP));
    // first entry after halt must be halt-capable
    s_next.halt_first = cpu_in.halted
                      | (s_reg.halt_first
                         & ~(entering & s_reg.kind == KIND_VEC));

    // software loads of the level bits (return, unmask, pop)
    if (cpu_in.level_we) begin
      s_next.level = cpu_in.level_in;
    end

    case (s_reg.st)
      // reset skips stacking and starts at the reset vector
      ST_RESET: begin
        s_next.kind  = KIND_RESET;
        s_next.vaddr = VEC_RESET;
        s_next.st    = ST_VECTOR;
      end
      // arbitration only between instructions
      ST_IDLE: begin
        if (cpu_in.instr_boundary) begin
          if (s_reg.trap_pend) begin
            s_next.kind  = KIND_TRAP;
            s_next.vaddr = VEC_TRAP;
            s_next.st    = ST_STACK;
          end else if (win_valid) begin
            s_next.kind  = KIND_VEC;
            s_next.idx   = win_idx;
            // vectors step down two bytes from the pin vector
            s_next.vaddr = VEC_TLI - {11'h000, win_idx, 1'b0};
            s_next.st    = ST_STACK;
          end
        end
      end
      // hold the push request until the core is done
      ST_STACK: begin
        if (cpu_in.stack_done) begin
          s_next.st = ST_VECTOR;
        end
      end
      // one cycle: pc load and level change
      ST_VECTOR: begin
        if (s_reg.kind == KIND_VEC && s_reg.idx != 4'h0) begin
          s_next.level = entry_prio;
        end else begin
          s_next.level = LVL3;
        end
        s_next.st = ST_IDLE;
      end
      default: begin
        s_next.st = ST_IDLE;
      end
    endcase

    // register reads captured in the setup phase
    if (apb_setup) begin
      case (apb_req.paddr)
        OFF_PRIO0, OFF_PRIO1, OFF_PRIO2, OFF_PRIO3:
          s_next.rdata = {24'h000000, s_reg.prio[apb_req.paddr[3:2]]};
        OFF_CFG:    s_next.rdata = {30'h0, s_reg.cfg};
        OFF_EXTSEL: s_next.rdata = {16'h0000, s_reg.extsel};
        OFF_STAT: begin
          s_next.rdata = 32'h00000000;
          s_next.rdata[STAT_PEND_LSB +: NVEC] = s_reg.lat;
          s_next.rdata[STAT_TRAP_BIT]         = s_reg.trap_pend;
          s_next.rdata[CC_LVL_HI_BIT]         = s_reg.level[1];
          s_next.rdata[CC_LVL_LO_BIT]         = s_reg.level[0];
          s_next.rdata[2:0]                   = s_reg.st;
        end
        default: s_next.rdata = 32'h00000000;
      endcase
    end

    // writes take effect in the access phase
    if (apb_wr) begin
      case (apb_req.paddr)
        OFF_PRIO0, OFF_PRIO1, OFF_PRIO2, OFF_PRIO3: begin
          for (int f = 0; f < 4; f++) begin
            // level-zero code cannot be stored
            if (apb_req.pwdata[2*f +: 2] != LVL0) begin
              s_next.prio[apb_req.paddr[3:2]][2*f +: 2] =
                apb_req.pwdata[2*f +: 2];
            end
          end
          if (apb_req.paddr == OFF_PRIO3) begin
            s_next.prio[3] = s_next.prio[3] | PRIO3_RO_MASK;
          end
        end
        OFF_CFG:    s_next.cfg    = apb_req.pwdata[1:0];
        OFF_EXTSEL: s_next.extsel = apb_req.pwdata[15:0];
        default: begin
          s_next.cfg = s_next.cfg;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register; nested pushes are not bounded here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg            <= '0;
      s_reg.st         <= ST_RESET;
      s_reg.kind       <= KIND_RESET;
      s_reg.vaddr      <= VEC_RESET;
      s_reg.level      <= LVL3;
      s_reg.prio       <= {4{PRIO_RST}};
      s_reg.cfg        <= CFG_RST;
      s_reg.extsel     <= EXTSEL_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_push_wait;
    (s_reg.st == ST_STACK) && !cpu_in.stack_done;
  endsequence

  sequence s_push_end;
    (s_reg.st == ST_STACK) && cpu_in.stack_done;
  endsequence

  stack_hold_a: assert property (s_push_wait |=> cpu_out.stack_req)
    else $error("stack request dropped early");
  vector_after_a: assert property (
    s_push_end |=> cpu_out.vector_load ##1 !cpu_out.vector_load)
    else $error("vector load not one cycle after stacking");
  entry_level_a: assert property (
    entering && s_reg.kind == KIND_VEC && s_reg.idx != 4'h0
    |=> cpu_out.level == $past(entry_prio))
    else $error("entry level not the stored one");
  nmi_level_a: assert property (
    entering && s_reg.kind != KIND_VEC |=> cpu_out.level == LVL3)
    else $error("non-maskable entry not at level three");
  reset_entry_a: assert property (
    s_reg.st == ST_RESET |=> cpu_out.vector_load
      && cpu_out.vector_addr == VEC_RESET && !cpu_out.stack_req)
    else $error("reset entry wrong");
  boundary_take_a: assert property (
    s_reg.st == ST_IDLE && cpu_in.instr_boundary
      && (win_valid || s_reg.trap_pend)
    |=> cpu_out.stack_req && (!$past(s_reg.trap_pend)
      || cpu_out.vector_addr == VEC_TRAP))
    else $error("boundary did not start entry");
  masked_stay_a: assert property (
    s_reg.st == ST_IDLE && !win_valid && !s_reg.trap_pend
    |=> !cpu_out.stack_req)
    else $error("entry started with nothing eligible");
  prio_keep_a: assert property (
    apb_wr && apb_req.paddr == OFF_PRIO0 && apb_req.pwdata[5:4] == LVL0
    |=> s_reg.prio[0][5:4] == $past(s_reg.prio[0][5:4]))
    else $error("level-zero code was stored");
  halt_first_a: assert property (
    entering && s_reg.kind == KIND_VEC && s_reg.halt_first
    |-> HALT_WAKE_MASK[s_reg.idx])
    else $error("first entry after halt not halt-capable");
  ext_clear_a: assert property (
    entry_hit[EXT_FIRST] && !ext_rise[0] |=> !s_reg.lat[EXT_FIRST])
    else $error("external latch not cleared on entry");

endmodule

/* shared/nic_pkg.sv */
// nic_pkg: constants, enums and carrier structs of the nested interrupt
// controller. Assumes one 25 MHz clock domain and an APB register port.
package nic_pkg;

  // vector set: index 0 is the top-level pin, 1..13 the maskable sources
  localparam int          NVEC          = 14;
  localparam int          EXT_FIRST     = 2;      // first external vector
  localparam int          EXT_GROUPS    = 4;      // external vectors
  localparam int          EXT_PINS      = 4;      // pins per external group
  localparam int          SUP_IDX       = 1;      // supply monitor vector
  // vectors able to end halt, index 13 down to 0
  localparam logic [13:0] HALT_WAKE_MASK = 14'h00BF;

  // vector addresses at the top of memory
  localparam logic [15:0] VEC_RESET     = 16'hFFFE;
  localparam logic [15:0] VEC_TRAP      = 16'hFFFC;
  localparam logic [15:0] VEC_TLI       = 16'hFFFA;
  localparam logic [15:0] VEC_TOP       = 16'hFFE0;

  // priority level codes of the two condition register bits
  localparam logic [1:0]  LVL0          = 2'h2;   // main program
  localparam logic [1:0]  LVL1          = 2'h1;
  localparam logic [1:0]  LVL2          = 2'h0;
  localparam logic [1:0]  LVL3          = 2'h3;   // interrupts disabled
  localparam int          CC_LVL_HI_BIT = 5;
  localparam int          CC_LVL_LO_BIT = 3;

  // register offsets (byte addresses)
  localparam logic [11:0] OFF_PRIO0     = 12'h000;
  localparam logic [11:0] OFF_PRIO1     = 12'h004;
  localparam logic [11:0] OFF_PRIO2     = 12'h008;
  localparam logic [11:0] OFF_PRIO3     = 12'h00C;
  localparam logic [11:0] OFF_CFG       = 12'h010;
  localparam logic [11:0] OFF_EXTSEL    = 12'h014;
  localparam logic [11:0] OFF_STAT      = 12'h018;

  // field positions and reset values
  localparam int          CFG_TLI_RISE_BIT = 0;
  localparam int          CFG_SUP_IE_BIT   = 1;
  localparam int          STAT_PEND_LSB    = 16;
  localparam int          STAT_TRAP_BIT    = 30;
  localparam logic [7:0]  PRIO_RST      = 8'hFF;
  localparam logic [7:0]  PRIO3_RO_MASK = 8'hF0;  // upper nibble reads one
  localparam logic [1:0]  CFG_RST       = 2'h1;
  localparam logic [15:0] EXTSEL_RST    = 16'h0000;

  typedef enum logic [2:0] {
    ST_RESET  = 3'b000,
    ST_IDLE   = 3'b001,
    ST_STACK  = 3'b010,
    ST_VECTOR = 3'b011
  } nic_state_e;

  typedef enum logic [1:0] {
    KIND_VEC   = 2'b00,
    KIND_TRAP  = 2'b01,
    KIND_RESET = 2'b10
  } nic_kind_e;

  typedef struct packed {
    logic [11:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } nic_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } nic_apb_rsp_s;

  typedef struct packed {
    logic       instr_boundary;   // pulse: instruction just finished
    logic       trap_exec;        // pulse: trap instruction executed
    logic       stack_done;       // pulse: four registers pushed
    logic       level_we;         // pulse: cpu loads priority bits
    logic [1:0] level_in;         // value for level_we
    logic       halted;
    logic       waiting;
  } nic_cpu_in_s;

  typedef struct packed {
    logic        stack_req;       // level: push pc, x, a, cc
    logic        vector_load;     // pulse: load pc from vector_addr
    logic [15:0] vector_addr;
    logic [1:0]  level;           // condition register bits 5 and 3
    logic        wake;
  } nic_cpu_out_s;

  typedef struct packed {
    nic_state_e        st;
    nic_kind_e         kind;
    logic [3:0]        idx;
    logic [15:0]       vaddr;
    logic [1:0]        level;
    logic [3:0][7:0]   prio;
    logic [1:0]        cfg;
    logic [15:0]       extsel;
    logic [31:0]       rdata;
    logic [NVEC-1:0]   lat;
    logic              sup_lat;
    logic              trap_pend;
    logic              halt_first;
    logic              tli_q;
    logic [EXT_GROUPS-1:0] ext_q;
    logic [NVEC-1:0]   preq_q;
    logic              sup_q;
  } nic_state_s;

  // software rank: 0 for main up to 3 for disabled
  function automatic logic [2:0] nic_rank(input logic [1:0] code);
    case (code)
      LVL0:    nic_rank = 3'h0;
      LVL1:    nic_rank = 3'h1;
      LVL2:    nic_rank = 3'h2;
      default: nic_rank = 3'h3;
    endcase
  endfunction

endpackage

/* rtl/nic_arbiter.sv */
// nic_arbiter: picks the pending vector with the best software rank,
// hardware order breaking ties. Assumes latched pending bits as input.
`timescale 1ns/10ps
module nic_arbiter
  import nic_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic [NVEC-1:0]   pending,
  input  wire logic [2*NVEC-1:0] prio_flat,
  input  wire logic [1:0]        cur_level,
  input  wire logic              halt_only,
  output logic                   win_valid,
  output logic [3:0]             win_idx
);

  logic [NVEC-1:0] elig;          // may be taken now
  logic [2:0]      key [NVEC];    // software rank per vector
  logic [2:0]      best_key;      // rank of the current winner

  ////////////////////////////////////////////////////////////////////////
  // per vector eligibility
  for (genvar i = 0; i < NVEC; i++) begin : g_vec
    if (i == 0) begin : g_tli
      // pin interrupt outranks every software level
      assign key[i]  = 3'h4;
      assign elig[i] = pending[i] & (~halt_only | HALT_WAKE_MASK[i]);
    end else begin : g_mask
      assign key[i]  = nic_rank(prio_flat[2*i +: 2]);
      // must beat the running level, else stays pending
      assign elig[i] = pending[i] & (~halt_only | HALT_WAKE_MASK[i])
                     & (key[i] > nic_rank(cur_level));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pick: best rank, lower index wins a tie
  always_comb begin
    win_valid = 1'b0;
    win_idx   = 4'h0;
    best_key  = 3'h0;
    // walk down from the top index so the lower index overwrites ties
    for (int j = NVEC - 1; j >= 0; j--) begin
      if (elig[j] && (!win_valid || key[j] >= best_key)) begin
        win_valid = 1'b1;
        win_idx   = 4'(j);
        best_key  = key[j];
      end
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  win_elig_a: assert property (win_valid |-> elig[win_idx])
    else $error("winner is not eligible");
  win_best_a: assert property (
    elig[0] |-> win_valid && win_idx == 4'h0)
    else $error("winner outranked by pin interrupt");

endmodule

/* testbench/nic_cpu_model.sv */
// nic_cpu_model: core side of the entry handshake; pushes pc, x, a, cc
// and reports stack_done after a chosen delay.
// Assumes stack_req holds until stack_done has been sampled.
`timescale 1ns/10ps
module nic_cpu_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       stack_req,
  input  wire logic [3:0] dly,        // extra push cycles
  output logic            stack_done
);
  logic [3:0] cnt_reg;                // cycles spent pushing
  // no overflow report: stack depth is software's problem
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg    <= 4'h0;
      stack_done <= 1'b0;
    end else if (stack_done || !stack_req) begin
      cnt_reg    <= 4'h0;
      stack_done <= 1'b0;
    end else if (cnt_reg == dly) begin
      stack_done <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end
endmodule

/* testbench/nested_interrupt_controller_test.sv */
// nested_interrupt_controller_test: seeded bench of nic_core.
// Assumes a 25 MHz pclk and the nic_cpu_model partner.
`timescale 1ns/10ps
module nested_interrupt_controller_test import nic_pkg::*;;
  logic         pclk, presetn, tli_pin, stack_done, err, sup;
  logic [15:0]  ext;                 // external pins, 4 groups of 4
  logic [13:0]  flag, irq_en, clr;   // peripheral side, index = vector
  logic [3:0]   dly;                 // partner push delay
  logic [31:0]  rd, seed;
  int           fail_count, check_count, a, b;
  nic_apb_req_s apb_req;
  nic_apb_rsp_s apb_rsp;
  nic_cpu_in_s  cpu_d, cpu_in;
  nic_cpu_out_s cpu_out;
  // stack_done belongs to the partner, the rest to the bench
  always_comb begin
    cpu_in            = cpu_d;
    cpu_in.stack_done = stack_done;
  end
  nic_core DUT (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .cpu_in(cpu_in), .cpu_out(cpu_out),
    .tli_pin(tli_pin), .ext_pins(ext), .periph_flag(flag),
    .periph_irq_en(irq_en), .periph_clear(clr),
    .supply_monitor_flag(sup));
  nic_cpu_model partner (.pclk(pclk), .presetn(presetn),
    .stack_req(cpu_out.stack_req), .dly(dly), .stack_done(stack_done));
  ////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  // vector address of index i
  function automatic logic [15:0] vaddr(input int i);
    return VEC_TLI - 16'(2 * i);
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one apb transfer, request held until pready is sampled
  task automatic apb(input logic w, input logic [11:0] ad,
                     input logic [31:0] wd);
    @(posedge pclk);
    apb_req <= '{ad, 1'b1, 1'b0, w, wd};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    do @(posedge pclk); while (apb_rsp.pready !== 1'b1);
    rd  = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req.psel    <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask
  task automatic bound();
    @(posedge pclk);
    cpu_d.instr_boundary <= 1'b1;
    @(posedge pclk);
    cpu_d.instr_boundary <= 1'b0;
  endtask
  // boundary, then expect entry to vector ea at level el
  task automatic take(input logic [15:0] ea, input logic [1:0] el);
    dly  <= seed[3:0] & 4'h3;  // prompt or slow partner
    seed = xs(seed);
    bound();
    repeat (30) begin
      @(posedge pclk);
      #1;
      if (cpu_out.vector_load === 1'b1) break;
    end
    chk(32'(cpu_out.vector_load), 32'h1);
    chk(32'(cpu_out.vector_addr), 32'(ea));
    @(posedge pclk);
    #1;
    chk(32'(cpu_out.level), 32'(el));
  endtask
  task automatic none();
    bound();
    repeat (4) @(posedge pclk);
    #1;
    chk(32'(cpu_out.stack_req), 32'h0);
  endtask
  task automatic lvl(input logic [1:0] c);
    @(posedge pclk);
    cpu_d.level_we <= 1'b1;
    cpu_d.level_in <= c;
    @(posedge pclk);
    cpu_d.level_we <= 1'b0;
  endtask
  task automatic clrp(input int i);
    @(posedge pclk);
    clr[i]  <= 1'b1;
    flag[i] <= 1'b0;
    @(posedge pclk);
    clr[i] <= 1'b0;
  endtask
  task automatic print_verdict();
    $display("checks=%0d fails=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // hang guard, far beyond the run's length
  initial begin
    repeat (6000) @(posedge pclk);
    fail_count++;
    print_verdict();
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {presetn, tli_pin, flag, irq_en, clr, dly, ext, sup} = '0;
    {apb_req, cpu_d, fail_count, check_count} = '0;
    seed = 32'd61;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1;
    chk(32'(cpu_out.vector_load), 32'h1);
    chk(32'(cpu_out.vector_addr), 32'(VEC_RESET));
    @(posedge pclk);
    #1;
    chk(32'(cpu_out.level), 32'(LVL3));
    apb(1'b0, OFF_PRIO3, 32'h0);
    chk(rd, 32'hFF);
    apb(1'b1, OFF_PRIO0, 32'hCF);
    apb(1'b1, OFF_PRIO0, 32'h64);
    apb(1'b0, OFF_PRIO0, 32'h0);
    chk(rd, 32'h44);
    apb(1'b0, 12'h01C, 32'h0);
    chk(32'(err), 32'h1);
    // random adjacent pair among vectors 8..13, both at level 3
    a = 8 + int'(seed % 5);
    b = a + 1;
    seed = xs(seed);
    lvl(LVL0);
    flag[a] <= 1'b1;
    flag[b] <= 1'b1;
    none();
    @(posedge pclk);
    irq_en[a] <= 1'b1;
    irq_en[b] <= 1'b1;
    take(vaddr(a), LVL3);
    clrp(a);
    none();
    lvl(LVL0);
    take(vaddr(b), LVL3);
    clrp(b);
    lvl(LVL0);
    flag[a] <= 1'b1;
    clrp(a);
    none();
    lvl(LVL3);
    tli_pin <= 1'b1;
    take(VEC_TLI, LVL3);
    // return from the pin routine first: no trap inside it
    lvl(LVL0);
    @(posedge pclk);
    cpu_d.trap_exec <= 1'b1;
    @(posedge pclk);
    cpu_d.trap_exec <= 1'b0;
    take(VEC_TRAP, LVL3);
    // external group 0, pin 1: vector 2 stored at level two
    apb(1'b1, OFF_EXTSEL, 32'h2);
    lvl(LVL0);
    ext[1] <= 1'b1;
    take(vaddr(EXT_FIRST), LVL2);
    apb(1'b0, OFF_STAT, 32'h0);
    chk(32'(rd[STAT_PEND_LSB + EXT_FIRST]), 32'h0);
    // supply monitor on vector 1, stored at level one
    apb(1'b1, OFF_CFG, 32'h3);
    lvl(LVL0);
    sup <= 1'b1;
    take(vaddr(SUP_IDX), LVL1);
    // halt: vector 7 at level one may wake, vector a may not
    apb(1'b1, OFF_PRIO1, 32'h7F);
    lvl(LVL0);
    cpu_d.halted <= 1'b1;
    flag[a]      <= 1'b1;
    repeat (3) @(posedge pclk);
    #1;
    chk(32'(cpu_out.wake), 32'h0);
    @(posedge pclk);
    flag[7]   <= 1'b1;
    irq_en[7] <= 1'b1;
    repeat (2) @(posedge pclk);
    #1;
    chk(32'(cpu_out.wake), 32'h1);
    @(posedge pclk);
    cpu_d.halted <= 1'b0;
    take(vaddr(7), LVL1);
    take(vaddr(a), LVL3);
    print_verdict();
  end
endmodule
